// ---- design/wbl_regs.svh ----
`ifndef WBL_REGS_SVH
`define WBL_REGS_SVH

// table geometry
`define WBL_ENTRIES 256
`define WBL_CW 8
`define WBL_CHANS 3

// register indices, byte address is four times the index
`define WBL_IDX_CTRL 8'h2A
`define WBL_IDX_OPTS 8'h2B
`define WBL_IDX_STAT 8'h2C
`define WBL_IDX_EXIT 8'hFF

// control register fields
`define WBL_CTRL_PAGE_BIT 4
`define WBL_CTRL_WB_BIT 5
`define WBL_CTRL_SEL_LSB 6

// option register fields
`define WBL_OPT_RELOAD_BIT 0
`define WBL_OPT_MAPOVR_BIT 1
`define WBL_OPT_MAPVAL_BIT 2
`define WBL_OPT_DEPTH18_BIT 3
`define WBL_OPT_PRE_BIT 4
`define WBL_OPT_POST_BIT 5

// status register fields
`define WBL_STAT_LOCK_BIT 0
`define WBL_STAT_PAGE_BIT 1
`define WBL_STAT_ORDER_BIT 2
`define WBL_STAT_RELOAD_BIT 3

// output frame: two high, three low, two high, sent first bit on the left
`define WBL_CLK_PATTERN 7'h63
`define WBL_LANE_BITS 7
`define WBL_LANES 4

// positions in the synchronised pin vector
`define WBL_PIN_W 29
`define WBL_PIN_DE 24
`define WBL_PIN_VS 25
`define WBL_PIN_HS 26
`define WBL_PIN_CLK 27
`define WBL_PIN_STRAP 28

`endif

// ---- design/wbl_pkg.sv ----
`include "wbl_regs.svh"

package wbl_pkg;

  // table page selected by the control register
  typedef enum logic [3:0] {
    WBL_PG_MAIN = 4'h1,
    WBL_PG_RED = 4'h2,
    WBL_PG_GRN = 4'h4,
    WBL_PG_BLU = 4'h8
  } wbl_page_t;

  typedef struct packed {
    logic [`WBL_PIN_W-1:0] meta;
    logic [`WBL_PIN_W-1:0] sync;
    logic clk_d;
    logic stb;
    logic [23:0] rgb;
    logic [2:0] ctl;
    logic strap;
  } wbl_sync_t;

  typedef struct packed {
    logic [`WBL_CHANS-1:0][`WBL_ENTRIES-1:0][`WBL_CW-1:0] tab;
    wbl_page_t page;
    logic wb_en;
    logic locked;
    logic reload_en;
    logic map_ovr;
    logic map_val;
    logic depth18;
    logic pre_table_dither;
    logic post_table_dither;
    logic ack;
    logic [31:0] dat;
    logic s1_v;
    logic [2:0][7:0] s1_c;
    logic [2:0] s1_ctl;
    logic s2_v;
    logic [2:0][7:0] s2_c;
    logic [2:0] s2_ctl;
    logic [`WBL_LANES-1:0][`WBL_LANE_BITS-1:0] lane;
    logic [`WBL_LANE_BITS-1:0] clk_a;
    logic [`WBL_LANE_BITS-1:0] clk_b;
    logic frame;
  } wbl_core_t;

endpackage : wbl_pkg

// ---- design/wbl_pix_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// one pixel per strobe, from the pin synchroniser to the core
interface wbl_pix_if;
  logic stb;
  logic [23:0] rgb;
  logic [2:0] ctl;
  logic strap;
  modport src (output stb, output rgb, output ctl, output strap);
  modport snk (input stb, input rgb, input ctl, input strap);
endinterface : wbl_pix_if

`default_nettype wire

// ---- design/wbl_pix_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wbl_regs.svh"

module wbl_pix_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pix_clk_i,
  input wire logic [23:0] pix_rgb_i,
  input wire logic pix_hs_i,
  input wire logic pix_vs_i,
  input wire logic pix_de_i,
  input wire logic output_config_strap_i,
  wbl_pix_if.src pix
);

  wbl_pkg::wbl_sync_t st;
  wbl_pkg::wbl_sync_t next_st;
  logic fall;

  // every pin goes through two flops; only the second stage is looked at
  always_comb begin
    next_st = st;
    next_st.meta = {output_config_strap_i, pix_clk_i, pix_hs_i, pix_vs_i, pix_de_i, pix_rgb_i};
    next_st.sync = st.meta;
    next_st.clk_d = st.sync[`WBL_PIN_CLK];
    fall = st.clk_d & ~st.sync[`WBL_PIN_CLK];
    next_st.stb = fall;
    next_st.strap = st.sync[`WBL_PIN_STRAP];
    // data is taken mid-period, well away from its launching edge
    if (fall) begin
      next_st.rgb = st.sync[23:0];
      next_st.ctl = {st.sync[`WBL_PIN_DE], st.sync[`WBL_PIN_VS], st.sync[`WBL_PIN_HS]};
    end
    if (rst_i) begin
      next_st = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // interface straight from flops
  assign pix.stb = st.stb;
  assign pix.rgb = st.rgb;
  assign pix.ctl = st.ctl;
  assign pix.strap = st.strap;

endmodule : wbl_pix_sync

`default_nettype wire

// ---- design/wbl_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wbl_regs.svh"

// Overview of operation
// - one 28-bit output frame is produced for each pixel clock period
// - clock lane pattern per frame is two high, three low, two high
// - 24-bit or 18-bit output, mapping chosen by strap or register override
// - in 24-bit output, bit order select high puts colour MSBs on lane three, low puts LSBs; 18-bit leaves lane three zero
// - three tables, red green blue, each 256 entries of 8 bits
// - with white balance on, each component indexes its table for replacement
// - host writes every entry and reads it back in normal access
// - while a table page is selected the main registers are unreachable
// - any write to index 0xFF leaves the table page
// - after first enable table writes are blocked unless reload is enabled
// - reload updates apply while enabled, without disturbing the pixel stream
// - reload mode accepts partial updates and reads tables back as zero
// - post-table dither follows the tables, pre-table dither precedes them
module wbl_core #(
  parameter int ENTRIES = `WBL_ENTRIES,
  parameter int CW = `WBL_CW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_clk_i,
  input wire logic [23:0] pix_rgb_i,
  input wire logic pix_hs_i,
  input wire logic pix_vs_i,
  input wire logic pix_de_i,
  input wire logic output_config_strap_i,
  output logic [27:0] lvds_data_o,
  output logic [6:0] lvds_clock_out_a_o,
  output logic [6:0] lvds_clock_out_b_o,
  output logic lvds_frame_o
);

  // the packed state type fixes the table shape
  if (ENTRIES != `WBL_ENTRIES || CW != `WBL_CW || ENTRIES != (1 << CW)) begin : g_chk
    $error("wbl_core: table shape not supported");
  end

  wbl_pkg::wbl_core_t st;
  wbl_pkg::wbl_core_t next_st;

  wbl_pix_if pix ();

  // pin synchroniser and pixel strobe
  wbl_pix_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pix_clk_i(pix_clk_i),
    .pix_rgb_i(pix_rgb_i),
    .pix_hs_i(pix_hs_i),
    .pix_vs_i(pix_vs_i),
    .pix_de_i(pix_de_i),
    .output_config_strap_i(output_config_strap_i),
    .pix(pix.src)
  );

  logic [2:0][7:0] in_c;
  logic [2:0][7:0] pre_c;
  logic [2:0][7:0] look_c;
  logic [2:0][7:0] post_c;
  logic [2:0][5:0] lo6;
  logic [2:0][1:0] hi2;
  logic order_msb;

  // strap sets the mapping unless software overrides it
  assign order_msb = st.map_ovr ? st.map_val : pix.strap;

  assign in_c = {pix.rgb[7:0], pix.rgb[15:8], pix.rgb[23:16]};

  // per channel datapath: pre dither, table, post dither, lane split
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [6:0] rnd;

    // stand-in pre-table reduction: drops the two LSBs ahead of the table
    assign pre_c[c] = st.pre_table_dither ? {in_c[c][7:2], 2'h0} : in_c[c];

    // each component indexes its own table, bypass keeps the same stage
    assign look_c[c] = st.wb_en ? st.tab[c][st.s1_c[c]] : st.s1_c[c];

    // stand-in post-table reduction to 6 bits, rounding with saturation
    assign rnd = {1'b0, st.s2_c[c][7:2]} + {6'h00, st.s2_c[c][1]};
    assign post_c[c] = !st.post_table_dither ? st.s2_c[c] :
                       rnd[6] ? 8'hFC : {rnd[5:0], 2'h0};

    // 18-bit keeps the six MSBs; 24-bit order picks where the spare pair goes
    assign lo6[c] = (order_msb && !st.depth18) ? post_c[c][5:0] : post_c[c][7:2];
    assign hi2[c] = st.depth18 ? 2'h0 :
                    order_msb ? post_c[c][7:6] : post_c[c][1:0];
  end

  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] rdata;
  logic [1:0] ch;
  logic in_page;
  logic reload_mode;
  logic [1:0] sel_code;

  always_comb begin
    next_st = st;

    // classic wishbone: answer one cycle after the strobe, drop it after one
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    wr = req & wb_we_i & wb_sel_i[0];
    idx = wb_adr_i[9:2];
    wd = wb_dat_i[7:0];
    rdata = 8'h00;
    next_st.ack = req;

    in_page = st.page != wbl_pkg::WBL_PG_MAIN;
    reload_mode = st.locked & st.reload_en;

    // page to channel index
    case (st.page)
      wbl_pkg::WBL_PG_RED: ch = 2'h0;
      wbl_pkg::WBL_PG_GRN: ch = 2'h1;
      wbl_pkg::WBL_PG_BLU: ch = 2'h2;
      default: ch = 2'h0;
    endcase

    // control register readback of the current page
    case (st.page)
      wbl_pkg::WBL_PG_RED: sel_code = 2'h1;
      wbl_pkg::WBL_PG_GRN: sel_code = 2'h2;
      wbl_pkg::WBL_PG_BLU: sel_code = 2'h3;
      default: sel_code = 2'h0;
    endcase

    if (in_page) begin
      // whole address space maps onto the selected table
      if (wr && (!st.locked || st.reload_en)) begin
        next_st.tab[ch][idx] = wd;
      end
      if (!reload_mode) begin
        rdata = st.tab[ch][idx];
      end
      if (wr && idx == `WBL_IDX_EXIT) begin
        next_st.page = wbl_pkg::WBL_PG_MAIN;
      end
    end else begin
      // main page; nothing here is reachable while a table page is open
      case (idx)
        `WBL_IDX_CTRL: begin
          rdata = {sel_code, st.wb_en, 1'b0, 4'h0};
          if (wr) begin
            if (wd[`WBL_CTRL_PAGE_BIT]) begin
              // a page write only opens a table: load sequences carry bit 5 along,
              // and letting it lock here would refuse the very load it starts
              case (wd[`WBL_CTRL_SEL_LSB+:2])
                2'h1: next_st.page = wbl_pkg::WBL_PG_RED;
                2'h2: next_st.page = wbl_pkg::WBL_PG_GRN;
                2'h3: next_st.page = wbl_pkg::WBL_PG_BLU;
                default: next_st.page = wbl_pkg::WBL_PG_MAIN;
              endcase
            end else begin
              next_st.wb_en = wd[`WBL_CTRL_WB_BIT];
              // first enable ends power-on initialisation
              if (wd[`WBL_CTRL_WB_BIT]) begin
                next_st.locked = 1'b1;
              end
            end
          end
        end
        `WBL_IDX_OPTS: begin
          rdata = {2'h0, st.post_table_dither, st.pre_table_dither,
                   st.depth18, st.map_val, st.map_ovr, st.reload_en};
          if (wr) begin
            next_st.reload_en = wd[`WBL_OPT_RELOAD_BIT];
            next_st.map_ovr = wd[`WBL_OPT_MAPOVR_BIT];
            next_st.map_val = wd[`WBL_OPT_MAPVAL_BIT];
            next_st.depth18 = wd[`WBL_OPT_DEPTH18_BIT];
            next_st.pre_table_dither = wd[`WBL_OPT_PRE_BIT];
            next_st.post_table_dither = wd[`WBL_OPT_POST_BIT];
          end
        end
        `WBL_IDX_STAT: begin
          // read only view of the block's own state
          rdata = {4'h0, reload_mode, order_msb, 1'b0, st.locked};
        end
        default: begin
          rdata = 8'h00; // unmapped: acked, reads zero, writes dropped
        end
      endcase
    end

    if (req) begin
      next_st.dat = {24'h000000, rdata};
    end

    // stage 1: capture the pixel after the pre-table stage
    next_st.s1_v = pix.stb;
    if (pix.stb) begin
      next_st.s1_c = pre_c;
      next_st.s1_ctl = pix.ctl;
    end

    // stage 2: table or bypass, both in this one stage
    next_st.s2_v = st.s1_v;
    if (st.s1_v) begin
      next_st.s2_c = look_c;
      next_st.s2_ctl = st.s1_ctl;
    end

    // stage 3: one frame per pixel; table writes land between pixels
    next_st.frame = st.s2_v;
    if (st.s2_v) begin
      next_st.lane[0] = {lo6[1][0], lo6[0]};
      next_st.lane[1] = {lo6[2][1:0], lo6[1][5:1]};
      next_st.lane[2] = {st.s2_ctl, lo6[2][5:2]};
      next_st.lane[3] = {1'b0, hi2[2], hi2[1], hi2[0]};
      next_st.clk_a = `WBL_CLK_PATTERN;
      next_st.clk_b = `WBL_CLK_PATTERN;
    end

    // synchronous reset; tables clear too so readback is defined
    if (rst_i) begin
      next_st = '0;
      next_st.page = wbl_pkg::WBL_PG_MAIN;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // outputs straight from flops
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign lvds_data_o = st.lane;
  assign lvds_clock_out_a_o = st.clk_a;
  assign lvds_clock_out_b_o = st.clk_b;
  assign lvds_frame_o = st.frame;

endmodule : wbl_core

`default_nettype wire

// ---- sim/wbl_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

// watches the bus answer and the output frame timing of the core
module wbl_core_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pix_clk_i,
  input wire logic [27:0] lvds_data_o,
  input wire logic [6:0] lvds_clock_out_a_o,
  input wire logic [6:0] lvds_clock_out_b_o,
  input wire logic lvds_frame_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // a request not yet answered, and the quiet spell a frame needs
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_gap;
    !lvds_frame_o [*3];
  endsequence

  property p_ack_ans; s_req |=> wb_ack_o; endproperty
  a_ack_ans: assert property (p_ack_ans) else $error("request left unanswered");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("read data upper bits set");
  property p_frame_gap; lvds_frame_o |=> s_gap; endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("frames too close");
  property p_clk_pat; lvds_frame_o |=> lvds_clock_out_a_o == 7'h63 && lvds_clock_out_b_o == 7'h63; endproperty
  a_clk_pat: assert property (p_clk_pat) else $error("clock lane pattern wrong");
  property p_hold; !lvds_frame_o |-> $stable(lvds_data_o) && $stable(lvds_clock_out_a_o); endproperty
  a_hold: assert property (p_hold) else $error("frame changed between strobes");
  property p_lat; $fell(pix_clk_i) |-> ##[5:7] lvds_frame_o; endproperty
  a_lat: assert property (p_lat) else $error("no frame for pixel clock period");
  property p_lane3; lvds_frame_o |=> !lvds_data_o[27]; endproperty
  a_lane3: assert property (p_lane3) else $error("spare lane bit set");
endmodule : wbl_core_chk

bind wbl_core wbl_core_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_clk_i(pix_clk_i), .lvds_data_o(lvds_data_o),
  .lvds_clock_out_a_o(lvds_clock_out_a_o), .lvds_clock_out_b_o(lvds_clock_out_b_o),
  .lvds_frame_o(lvds_frame_o));

`default_nettype wire

// ---- sim/wbl_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// panel end: latches one pixel word per frame strobe
module wbl_panel_model (
  input wire logic clk_i,
  input wire logic [27:0] lvds_data_i,
  input wire logic lvds_frame_i,
  output logic [27:0] pixel_o,
  output logic [15:0] frames_o
);
  initial begin
    pixel_o = 28'h0000000;
    frames_o = 16'h0000;
  end
  // strobe is one cycle wide, so each frame is counted exactly once
  always @(posedge clk_i) begin
    if (lvds_frame_i === 1'b1) begin
      pixel_o <= lvds_data_i;
      frames_o <= frames_o + 16'h0001;
    end
  end
endmodule : wbl_panel_model

`default_nettype wire

// ---- sim/white_balance_lut_lvds_output_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module white_balance_lut_lvds_output_tb_top;
  // 8'h20 runs table results through the post-table dither
  localparam logic [7:0] mode_tab [6] = '{8'h00, 8'h02, 8'h06, 8'h0A, 8'h10, 8'h20};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pix_clk_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, frm;
  logic [23:0] rgb = 24'h000000;
  logic [2:0] ctl = 3'h0;
  logic strap = 1'b1;
  logic [27:0] lvd, seen;
  logic [6:0] cka, ckb;
  logic [15:0] nfr;
  logic [7:0] tab [3][256];
  logic [31:0] x = 32'h0000000B;
  logic [7:0] rd;
  logic ord = 1'b1, d18 = 1'b0, pre = 1'b0, post = 1'b0, wbe = 1'b0, lk = 1'b0;
  int failures = 0;
  int checks = 0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // pixel clock at 160 ns with its own phase, sampled by the core
  initial begin
    #3;
    forever #80 pix_clk_i = ~pix_clk_i;
  end

  wbl_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pix_clk_i(pix_clk_i), .pix_rgb_i(rgb), .pix_hs_i(ctl[0]), .pix_vs_i(ctl[1]), .pix_de_i(ctl[2]),
    .output_config_strap_i(strap), .lvds_data_o(lvd), .lvds_clock_out_a_o(cka),
    .lvds_clock_out_b_o(ckb), .lvds_frame_o(frm));
  wbl_panel_model pan_u (.clk_i(clk_i), .lvds_data_i(lvd), .lvds_frame_i(frm), .pixel_o(seen),
    .frames_o(nfr));

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic guard(input logic ok);
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask : guard

  function automatic logic [7:0] rnd8();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x[7:0];
  endfunction : rnd8

  // expected frame word: pre dither, table, post dither, then lane packing
  function automatic logic [27:0] lanes(input logic [23:0] p, input logic [2:0] c);
    logic [7:0] v [3];
    logic [5:0] s [3];
    logic [1:0] t [3];
    for (int i = 0; i < 3; i++) begin
      v[i] = p[16 - 8 * i +: 8];
      if (pre) v[i] = v[i] & 8'hFC;
      if (wbe) v[i] = tab[i][v[i]];
      if (post) v[i] = (v[i] >= 8'hFE) ? 8'hFC : {v[i][7:2] + {5'h00, v[i][1]}, 2'b00};
      s[i] = (d18 || !ord) ? v[i][7:2] : v[i][5:0];
      t[i] = d18 ? 2'b00 : (ord ? v[i][7:6] : v[i][1:0]);
    end
    return {1'b0, t[2], t[1], t[0], c, s[2][5:2], s[2][1:0], s[1][5:1], s[1][0], s[0]};
  endfunction : lanes

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    guard(ack === 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // pixel set just after a rise so it is steady across the sampling fall
  task automatic px(input logic [23:0] p, input logic [2:0] c);
    int n;
    logic [15:0] f0;
    n = 0;
    while (pix_clk_i === 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    while (pix_clk_i !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    guard(n < 40);
    rgb <= p;
    ctl <= c;
    f0 = nfr;
    while (nfr === f0 && n < 80) begin @(posedge clk_i); n++; end
    guard(n < 80);
    chk({4'h0, seen}, {4'h0, lanes(p, c)});
    chk({18'h00000, cka, ckb}, {18'h00000, 7'h63, 7'h63});
  endtask : px

  task automatic burst();
    logic [7:0] c8;
    px(24'hFFFFFF, 3'h7);
    px(24'h000000, 3'h0);
    for (int i = 0; i < 4; i++) begin
      c8 = rnd8();
      px({rnd8(), rnd8(), rnd8()}, c8[2:0]);
    end
  endtask : burst

  task automatic set_opts(input logic [7:0] o);
    wb(1'b1, 8'h2B, o);
    wb(1'b0, 8'h2B, 8'h00);
    chk({24'h000000, rd}, {24'h000000, o});
    ord = o[1] ? o[2] : strap;
    d18 = o[3];
    pre = o[4];
    post = o[5];
    wb(1'b0, 8'h2C, 8'h00);
    chk({24'h000000, rd}, {28'h0000000, lk & o[0], ord, 1'b0, lk});
    burst();
  endtask : set_opts

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values of control, options, status and one unmapped index
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'h2A + i[7:0], 8'h00);
      chk({24'h000000, rd}, (i == 2) ? 32'h00000004 : 32'h00000000);
    end
    // initial load red, green, blue with white balance still off
    for (int t = 0; t < 3; t++) begin
      // page writes carry the enable bit too; they must not lock the load they open
      wb(1'b1, 8'h2A, {t[1:0] + 2'h1, 6'h30});
      for (int i = 0; i < 256; i++) begin
        tab[t][i] = rnd8();
        wb(1'b1, i[7:0], tab[t][i]);
      end
    end
    // in the table page even the main indices read table entries
    wb(1'b1, 8'h2A, 8'hB0);
    for (int i = 0; i < 255; i++) begin
      wb(1'b0, i[7:0], 8'h00);
      chk({24'h000000, rd}, {24'h000000, tab[1][i]});
    end
    wb(1'b1, 8'hFF, tab[1][255]);
    foreach (mode_tab[k]) set_opts(mode_tab[k]);
    // enabling white balance locks the tables against plain rewrites
    wb(1'b1, 8'h2A, 8'h20);
    wb(1'b0, 8'h2A, 8'h00);
    chk({24'h000000, rd}, 32'h00000020);
    wbe = 1'b1;
    lk = 1'b1;
    foreach (mode_tab[k]) set_opts(mode_tab[k]);
    wb(1'b1, 8'h2A, 8'h70);
    wb(1'b1, 8'h00, ~tab[0][0]);
    wb(1'b0, 8'h00, 8'h00);
    chk({24'h000000, rd}, {24'h000000, tab[0][0]});
    wb(1'b1, 8'hFF, tab[0][255]);
    // reload takes a partial update and hides the table contents
    set_opts(8'h01);
    wb(1'b1, 8'h2A, 8'h70);
    tab[0][0] = ~tab[0][0];
    wb(1'b1, 8'h00, tab[0][0]);
    wb(1'b0, 8'h00, 8'h00);
    chk({24'h000000, rd}, 32'h00000000);
    wb(1'b1, 8'hFF, tab[0][255]);
    px(24'h00FFFF, 3'h1);
    burst();
    // with the override cleared the strap alone picks the bit order
    strap <= 1'b0;
    set_opts(8'h00);
    tally_and_finish();
  end
endmodule : white_balance_lut_lvds_output_tb_top

`default_nettype wire
